// ### hw/lowpower_ctrl_pkg.sv
// Constants shared by the serial command controller and its serial port core.
// Assumes a single 250 MHz clock domain for every user of this package.
package lowpower_ctrl_pkg;
   localparam int unsigned CLK_HZ = 250_000_000;
   localparam int unsigned BAUD_RATE = 115200;
   localparam int unsigned BAUD_DIV = CLK_HZ / BAUD_RATE;
   localparam int unsigned DATA_BITS = 8;
   localparam int unsigned STOP_BIT_IDX = DATA_BITS + 1;
   localparam logic [7:0] HANDSHAKE_BYTE = 8'h78;
   localparam logic [7:0] ACK_BYTE = 8'h61;
   localparam logic [1:0] XFER_WRITE = 2'h1;
   localparam logic [1:0] XFER_READ = 2'h2;
   localparam logic [31:0] PWR_SAVE_OFS = 32'h0000_0084;
   localparam logic [31:0] REFRESH_OFS = 32'h0000_0008;
   localparam logic [31:0] POWERDOWN_OFS = 32'h0000_0010;
   localparam logic [31:0] STATUS_OFS = 32'h0000_00c0;
   localparam logic [31:0] STOPCLK_OFF = 32'h0000_0414;
   localparam logic [31:0] STOPCLK_ON = 32'h0000_0415;
   localparam logic [31:0] SREF_OFF = 32'h0000_0c88;
   localparam logic [31:0] SREF_ON = 32'h0000_0ca8;
   localparam int unsigned TP_WORDS = 8;
   localparam int unsigned TP_BYTES = 16;
   localparam logic [3:0] LAST_ACK_IDX = 4'h0;
   localparam logic [3:0] LAST_REG_IDX = 4'h3;
   localparam logic [3:0] LAST_TP_IDX = 4'hf;
   localparam logic [1:0] HTRANS_IDLE = 2'h0;
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
   localparam logic [2:0] HSIZE_WORD = 3'h2;
   typedef enum {K_ACK, K_REG, K_TP} send_kind_t;
   typedef enum {S_WAIT_HS, S_SEND, S_SEND_WAIT, S_IDLE, S_AHB_ADDR, S_AHB_DATA, S_XFER_START, S_XFER_WAIT}
      ctrl_state_t;
endpackage

// ### hw/serial_byte_if.sv
// Byte stream between the command controller and the serial port core.
// Assumes both ends run on the same clock.
`timescale 1ns/1ns
interface serial_byte_if;
   logic [7:0] rx_data;
   logic rx_valid;
   logic [7:0] tx_data;
   logic tx_start;
   logic tx_busy;
   modport core (output rx_data, output rx_valid, input tx_data, input tx_start, output tx_busy);
   modport ctrl (input rx_data, input rx_valid, output tx_data, output tx_start, input tx_busy);
endinterface

// ### hw/serial_port_core.sv
// Serial port core: 8 data bits, no parity, one stop bit, fixed baud divider.
// Assumes the receive pin is already synchronous to core_clk.
`timescale 1ns/1ns
module serial_port_core
   import lowpower_ctrl_pkg::*;
#(
   parameter int unsigned DIV = BAUD_DIV
) (
   input wire logic core_clk,
   input wire logic rst_b,
   input wire logic uart_rx,
   output logic uart_tx,
   serial_byte_if.core bus
);
   logic rx_busy;
   logic [15:0] rx_cnt;
   logic [3:0] rx_bit;
   logic [7:0] rx_shift;
   logic [15:0] tx_cnt;
   logic [3:0] tx_bit;
   logic [7:0] tx_shift;
   wire rx_tick = rx_cnt == 16'h0;
   wire tx_tick = tx_cnt == 16'h0;
   wire tx_go = bus.tx_start && !bus.tx_busy;

   // Receiver samples each bit at its middle; a frame with a low stop bit is dropped.
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         rx_busy <= 1'b0;
         rx_cnt <= 16'h0;
         rx_bit <= 4'h0;
         rx_shift <= 8'h0;
         bus.rx_valid <= 1'b0;
         bus.rx_data <= 8'h0;
      end else begin
         bus.rx_valid <= 1'b0;
         if (!rx_busy) begin
            if (!uart_rx) begin
               rx_busy <= 1'b1;
               rx_cnt <= 16'(DIV / 2);
               rx_bit <= 4'h0;
            end
         end else if (!rx_tick) begin
            rx_cnt <= rx_cnt - 16'h1;
         end else begin
            rx_cnt <= 16'(DIV - 1);
            rx_bit <= rx_bit + 4'h1;
            if (rx_bit == 4'h0 && uart_rx) begin
               rx_busy <= 1'b0;
            end else if (rx_bit == 4'(STOP_BIT_IDX)) begin
               rx_busy <= 1'b0;
               bus.rx_valid <= uart_rx;
               bus.rx_data <= rx_shift;
            end else if (rx_bit != 4'h0) begin
               rx_shift <= {uart_rx, rx_shift[7:1]};
            end
         end
      end
   end

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         uart_tx <= 1'b1;
         bus.tx_busy <= 1'b0;
         tx_cnt <= 16'h0;
         tx_bit <= 4'h0;
         tx_shift <= 8'h0;
      end else if (tx_go) begin
         uart_tx <= 1'b0;
         bus.tx_busy <= 1'b1;
         tx_cnt <= 16'(DIV - 1);
         tx_bit <= 4'h0;
         tx_shift <= bus.tx_data;
      end else if (bus.tx_busy) begin
         if (!tx_tick) begin
            tx_cnt <= tx_cnt - 16'h1;
         end else if (tx_bit == 4'(STOP_BIT_IDX)) begin
            bus.tx_busy <= 1'b0;
         end else begin
            uart_tx <= (tx_bit == 4'(DATA_BITS)) ? 1'b1 : tx_shift[0];
            tx_shift <= {1'b0, tx_shift[7:1]};
            tx_bit <= tx_bit + 4'h1;
            tx_cnt <= 16'(DIV - 1);
         end
      end
   end

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_b);
   start_bit_low_a: assert property (tx_go |=> (!uart_tx)[*8])
      else $error("Start bit not driven low.");
   rx_frame_end_a: assert property (bus.rx_valid |-> $past(rx_bit) == 4'(STOP_BIT_IDX) && !rx_busy)
      else $error("Byte delivered before the stop bit.");
endmodule

// ### hw/uart_lowpower_command_control.sv
// Serial command controller: handshake, command decode, AHB-Lite configuration
// writes and reads, AXI transfer starts, and throughput read-back over the UART.
// Assumes an external AXI master that pulses axi_done and fills the throughput words.
`timescale 1ns/1ns
// How it works
// - Host sends handshake first; device waits for it.
// - Handshake answered with acknowledge byte, then wait.
// - Write command starts the AXI write.
// - Deep power-down entry gives one AHB write.
// - Exit-and-read gives config write then AXI read.
// - After transfers, throughput bytes go to host.
// - Power-saving commands become AHB-Lite register writes.
// - Link is 115200 baud, 8 bits, no parity.
// - Throughput RAM: 8x16 written, 16x8 read.
// - AHB-Lite master reaches the controller configuration registers.
// - Bits 5:2 select register, 1:0 transfer.
// - Stop clock: offset 0x084, 0x414 or 0x415.
// - Self-refresh: offset 0x008, 0xc88 or 0xca8.
// - Power-down: offset 0x010, value 0 to 3.
module uart_lowpower_command_control
   import lowpower_ctrl_pkg::*;
#(
   parameter logic [31:0] CFG_BASE = 32'h0000_0000,
   parameter int unsigned DIV = BAUD_DIV
) (
   input wire logic core_clk,
   input wire logic rst_b,
   input wire logic uart_rx,
   output logic uart_tx,
   output logic hs_done,
   output logic axi_write_start,
   output logic axi_read_start,
   input wire logic axi_done,
   input wire logic tp_wr_en,
   input wire logic [2:0] tp_wr_addr,
   input wire logic [15:0] tp_wr_data,
   output logic [31:0] haddr,
   output logic [1:0] htrans,
   output logic hwrite,
   output logic [2:0] hsize,
   output logic [31:0] hwdata,
   input wire logic [31:0] hrdata,
   input wire logic hready,
   input wire logic hresp
);
   serial_byte_if bus ();

   serial_port_core #(.DIV(DIV)) port_core (
      .core_clk(core_clk),
      .rst_b(rst_b),
      .uart_rx(uart_rx),
      .uart_tx(uart_tx),
      .bus(bus.core)
   );

   ctrl_state_t state, next_state;
   send_kind_t send_kind, next_kind;
   logic [7:0] cmd, next_cmd;
   logic [3:0] byte_idx, next_idx;
   logic [31:0] rd_word, next_rd;
   logic next_hs;
   logic [15:0] tp_mem [TP_WORDS];

   function automatic logic sel_is_write(input logic [3:0] sel);
      return sel >= 4'h1 && sel <= 4'h8;
   endfunction

   function automatic logic sel_is_read(input logic [3:0] sel);
      return sel >= 4'h9 && sel <= 4'hd;
   endfunction

   function automatic logic is_xfer(input logic [1:0] code);
      return code == XFER_WRITE || code == XFER_READ;
   endfunction

   function automatic logic [31:0] cfg_addr(input logic [3:0] sel);
      case (sel)
         4'h1, 4'h2, 4'h9: return CFG_BASE + PWR_SAVE_OFS;
         4'h3, 4'h4, 4'ha: return CFG_BASE + REFRESH_OFS;
         4'h5, 4'h6, 4'h7, 4'h8, 4'hb, 4'hc: return CFG_BASE + POWERDOWN_OFS;
         default: return CFG_BASE + STATUS_OFS;
      endcase
   endfunction

   function automatic logic [31:0] cfg_data(input logic [3:0] sel);
      logic [3:0] pd;
      pd = sel - 4'h5;
      case (sel)
         4'h1: return STOPCLK_OFF;
         4'h2: return STOPCLK_ON;
         4'h3: return SREF_OFF;
         4'h4: return SREF_ON;
         default: return {30'h0, pd[1:0]};
      endcase
   endfunction

   wire [3:0] rx_sel = bus.rx_data[5:2];
   wire rx_cfg = sel_is_write(rx_sel) || sel_is_read(rx_sel);
   wire cmd_wr = sel_is_write(cmd[5:2]);
   // Read port is 16 bytes: even index is the low byte of a 16-bit word.
   wire [15:0] tp_word = tp_mem[byte_idx[3:1]];
   wire [7:0] tp_byte = byte_idx[0] ? tp_word[15:8] : tp_word[7:0];
   wire [7:0] reg_byte = rd_word[8 * byte_idx[1:0] +: 8];
   wire [3:0] last_idx = (send_kind == K_ACK) ? LAST_ACK_IDX : (send_kind == K_REG) ? LAST_REG_IDX : LAST_TP_IDX;
   assign bus.tx_data = (send_kind == K_ACK) ? ACK_BYTE : (send_kind == K_REG) ? reg_byte : tp_byte;
   assign bus.tx_start = state == S_SEND && !bus.tx_busy;

   always_comb begin
      next_state = state;
      next_kind = send_kind;
      next_cmd = cmd;
      next_idx = byte_idx;
      next_rd = rd_word;
      next_hs = hs_done;
      case (state)
         S_WAIT_HS: begin
            if (bus.rx_valid && bus.rx_data == HANDSHAKE_BYTE) begin
               next_state = S_SEND;
               next_kind = K_ACK;
               next_idx = 4'h0;
            end
         end
         S_SEND: begin
            if (!bus.tx_busy) next_state = S_SEND_WAIT;
         end
         S_SEND_WAIT: begin
            if (!bus.tx_busy && byte_idx != last_idx) begin
               next_idx = byte_idx + 4'h1;
               next_state = S_SEND;
            end else if (!bus.tx_busy && send_kind == K_ACK) begin
               next_hs = 1'b1;
               next_state = S_IDLE;
            end else if (!bus.tx_busy && send_kind == K_REG && is_xfer(cmd[1:0])) begin
               next_state = S_XFER_START;
            end else if (!bus.tx_busy) begin
               next_state = S_IDLE;
            end
         end
         S_IDLE: begin
            if (bus.rx_valid) begin
               next_cmd = bus.rx_data;
               if (rx_cfg) next_state = S_AHB_ADDR;
               else if (is_xfer(bus.rx_data[1:0])) next_state = S_XFER_START;
            end
         end
         S_AHB_ADDR: begin
            if (hready) next_state = S_AHB_DATA;
         end
         S_AHB_DATA: begin
            if (hready && !cmd_wr) begin
               next_rd = hrdata;
               next_kind = K_REG;
               next_idx = 4'h0;
               next_state = S_SEND;
            end else if (hready && is_xfer(cmd[1:0])) begin
               next_state = S_XFER_START;
            end else if (hready) begin
               next_state = S_IDLE;
            end
         end
         S_XFER_START: next_state = S_XFER_WAIT;
         S_XFER_WAIT: begin
            if (axi_done) begin
               next_kind = K_TP;
               next_idx = 4'h0;
               next_state = S_SEND;
            end
         end
         default: next_state = S_WAIT_HS;
      endcase
   end

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         state <= S_WAIT_HS;
         send_kind <= K_ACK;
         cmd <= 8'h0;
         byte_idx <= 4'h0;
         rd_word <= 32'h0;
         hs_done <= 1'b0;
      end else begin
         state <= next_state;
         send_kind <= next_kind;
         cmd <= next_cmd;
         byte_idx <= next_idx;
         rd_word <= next_rd;
         hs_done <= next_hs;
      end
   end

   // Bus outputs are registered; address and data are loaded when a configuration command is taken.
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         htrans <= HTRANS_IDLE;
         haddr <= 32'h0;
         hwrite <= 1'b0;
         hsize <= HSIZE_WORD;
         hwdata <= 32'h0;
         axi_write_start <= 1'b0;
         axi_read_start <= 1'b0;
      end else begin
         htrans <= (next_state == S_AHB_ADDR) ? HTRANS_NONSEQ : HTRANS_IDLE;
         axi_write_start <= next_state == S_XFER_START && next_cmd[1:0] == XFER_WRITE;
         axi_read_start <= next_state == S_XFER_START && next_cmd[1:0] == XFER_READ;
         if (state == S_IDLE && next_state == S_AHB_ADDR) begin
            haddr <= cfg_addr(rx_sel);
            hwrite <= sel_is_write(rx_sel);
            hwdata <= cfg_data(rx_sel);
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (tp_wr_en) tp_mem[tp_wr_addr] <= tp_wr_data;
   end

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_b);

   wire cmd_in = state == S_IDLE && bus.rx_valid;

   no_early_bus_a: assert property (!hs_done |-> htrans == HTRANS_IDLE && !axi_write_start && !axi_read_start)
      else $error("Bus activity before handshake.");
   ack_reply_a: assert property (state == S_WAIT_HS && bus.rx_valid && bus.rx_data == HANDSHAKE_BYTE
      |=> bus.tx_start && bus.tx_data == ACK_BYTE)
      else $error("Handshake not acknowledged.");
   write_start_a: assert property (cmd_in && bus.rx_data == 8'h01 |=> axi_write_start ##1 !axi_write_start)
      else $error("Write command did not start one AXI write.");
   deep_entry_a: assert property (cmd_in && bus.rx_data == 8'h20 |=> htrans == HTRANS_NONSEQ && hwrite
      && haddr == CFG_BASE + POWERDOWN_OFS && hwdata == 32'h3)
      else $error("Deep power-down entry write wrong.");
   deep_exit_read_a: assert property (cmd_in && bus.rx_data == 8'h16 |=> hwrite && hwdata == 32'h0
      ##[1:300] axi_read_start)
      else $error("Exit and read did not write then read.");
   tp_return_a: assert property (state == S_XFER_WAIT && axi_done |=> bus.tx_start && byte_idx == 4'h0
      && send_kind == K_TP)
      else $error("Throughput not returned after transfer.");
   single_beat_a: assert property (htrans == HTRANS_NONSEQ && hready |=> htrans == HTRANS_IDLE)
      else $error("More than one AHB beat per command.");
   stop_clock_a: assert property (cmd_in && rx_sel == 4'h2 |=> haddr == CFG_BASE + PWR_SAVE_OFS
      && hwdata == STOPCLK_ON)
      else $error("Stop clock enable write wrong.");
   self_refresh_a: assert property (cmd_in && rx_sel == 4'h4 |=> haddr == CFG_BASE + REFRESH_OFS
      && hwdata == SREF_ON)
      else $error("Self-refresh enable write wrong.");
   nop_decode_a: assert property (cmd_in && rx_sel == 4'h0 && !is_xfer(bus.rx_data[1:0]) |=> state == S_IDLE)
      else $error("No-operation command left idle.");

   hs_cover: cover property ($rose(hs_done));
   cfg_cover: cover property (htrans == HTRANS_NONSEQ && hready && hwrite);
   reg_read_cover: cover property (state == S_SEND && send_kind == K_REG);
   tp_cover: cover property (state == S_SEND_WAIT && send_kind == K_TP && byte_idx == LAST_TP_IDX && !bus.tx_busy);
endmodule

// ### sim/host_uart_model.sv
// Host side of the serial link: sends command bytes and collects answer bytes.
// Assumes the same baud divider as the design and a line that idles high.
`timescale 1ns/1ns
module host_uart_model #(
   parameter int unsigned DIV = 16
) (
   input wire logic core_clk,
   output logic uart_rx,
   input wire logic uart_tx
);
   logic [7:0] rxq[$];
   initial uart_rx = 1'h1;
   task automatic send_byte(input logic [7:0] b);
      logic [9:0] f;
      f = {1'h1, b, 1'h0};
      for (int i = 0; i < 10; i++) begin
         @(negedge core_clk);
         uart_rx = f[i];
         repeat (DIV - 1) @(negedge core_clk);
      end
   endtask
   // Each answer frame is sampled mid-bit, least significant bit first.
   initial begin
      logic [7:0] b;
      forever begin
         @(negedge uart_tx);
         repeat (DIV / 2) @(posedge core_clk);
         for (int i = 0; i < 8; i++) begin
            repeat (DIV) @(posedge core_clk);
            b[i] = uart_tx;
         end
         repeat (DIV) @(posedge core_clk);
         rxq.push_back(b);
      end
   end
endmodule

// ### sim/tb.sv
// Testbench of the serial command controller with a host model, an AHB-Lite slave and an AXI stand-in.
// Assumes a shortened baud divider so that every frame lasts few clock cycles.
`timescale 1ns/1ns
module tb
   import lowpower_ctrl_pkg::*;
;
   localparam int unsigned SDIV = 16;
   logic core_clk, rst_b, uart_rx, uart_tx, hs_done, axi_write_start, axi_read_start, axi_done;
   logic tp_wr_en, hwrite, hready, hresp, a_wr, ph;
   logic [2:0] tp_wr_addr, hsize;
   logic [15:0] tp_wr_data, seed;
   logic [15:0] tp[8];
   logic [1:0] htrans;
   logic [31:0] haddr, hwdata, hrdata, a_addr, a_data, a_rdata;
   int n_mismatch, checks, n_ahb, n_wst, n_rst, cyc, a0;
   uart_lowpower_command_control #(.DIV(SDIV)) i_dut (.core_clk(core_clk), .rst_b(rst_b),
      .uart_rx(uart_rx), .uart_tx(uart_tx), .hs_done(hs_done), .axi_write_start(axi_write_start),
      .axi_read_start(axi_read_start), .axi_done(axi_done), .tp_wr_en(tp_wr_en), .tp_wr_addr(tp_wr_addr),
      .tp_wr_data(tp_wr_data), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
      .hwdata(hwdata), .hrdata(hrdata), .hready(hready), .hresp(hresp));
   host_uart_model #(.DIV(SDIV)) i_host (.core_clk(core_clk), .uart_rx(uart_rx), .uart_tx(uart_tx));
   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   function automatic logic [63:0] expect_cfg(input int s);
      case (s)
         1: return {32'h084, 32'h414};
         2: return {32'h084, 32'h415};
         3: return {32'h008, 32'hc88};
         4: return {32'h008, 32'hca8};
         9: return {32'h084, 32'h0};
         10: return {32'h008, 32'h0};
         11, 12: return {32'h010, 32'h0};
         13: return {STATUS_OFS, 32'h0};
         default: return {32'h010, 32'(s - 5)};
      endcase
   endfunction
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic final_report();
      $display("checks %0d mismatches %0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   task automatic wait_rx(input int n);
      for (int i = 0; i < 20000 && i_host.rxq.size() < n; i++) @(posedge core_clk);
      if (i_host.rxq.size() < n) n_mismatch++;
   endtask
   task automatic cfg(input int s);
      int n0;
      logic [63:0] e;
      n0 = n_ahb;
      e = expect_cfg(s);
      i_host.send_byte({2'h0, 4'(s), 2'h0});
      // Wait for the address phase and then for the end of its data phase.
      for (int i = 0; i < 2000 && (ph || n_ahb == n0); i++) @(posedge core_clk);
      chk(n_ahb - n0, 1);
      chk(a_addr, e[63:32]);
      chk(32'(a_wr), 32'(s < 9));
      chk(32'(hsize), 32'(HSIZE_WORD));
      if (s < 9) chk(a_data, e[31:0]);
      else begin
         wait_rx(4);
         for (int i = 0; i < 4; i++) chk(32'(i_host.rxq.pop_front()), 32'(a_rdata[8*i +: 8]));
      end
   endtask
   task automatic xfer(input logic [7:0] cmd, input bit rd);
      int w0, r0;
      w0 = n_wst;
      r0 = n_rst;
      i_host.send_byte(cmd);
      for (int i = 0; i < 2000 && n_wst + n_rst == w0 + r0; i++) @(posedge core_clk);
      // A register read sends its four bytes before the transfer starts.
      for (int k = 0; i_host.rxq.size() > 0; k++) chk(32'(i_host.rxq.pop_front()), 32'(a_rdata[8*k +: 8]));
      for (int k = 0; k < 8; k++) begin
         @(negedge core_clk);
         tp_wr_en = 1'h1;
         tp_wr_addr = 3'(k);
         tp_wr_data = seed;
         tp[k] = seed;
      end
      @(negedge core_clk);
      tp_wr_en = 1'h0;
      axi_done = 1'h1;
      @(negedge core_clk);
      axi_done = 1'h0;
      chk(n_wst - w0, 32'(!rd));
      chk(n_rst - r0, 32'(rd));
      wait_rx(16);
      for (int k = 0; k < 16; k++) chk(32'(i_host.rxq.pop_front()), 32'(tp[k/2][8*(k%2) +: 8]));
   endtask
   initial begin
      core_clk = 1'h0;
      forever #2 core_clk = ~core_clk;
   end
   always @(posedge core_clk) begin
      cyc++;
      if (cyc == 40000) begin
         n_mismatch++;
         final_report();
      end
   end
   // Passive AHB-Lite monitor: address phase, then data phase on the next ready.
   always @(posedge core_clk) begin
      if (ph && hready) begin
         a_data = hwdata;
         a_rdata = hrdata;
      end
      if (htrans == HTRANS_NONSEQ && hready) begin
         n_ahb++;
         a_addr = haddr;
         a_wr = hwrite;
      end
      ph = (htrans == HTRANS_NONSEQ && hready) || (ph && !hready);
      n_wst += axi_write_start;
      n_rst += axi_read_start;
   end
   always @(negedge core_clk) begin
      seed = lfsr(seed);
      hready = |seed[1:0];
      hrdata = {seed, ~seed};
   end
   initial begin
      seed = 16'h0005;
      ph = 1'h0;
      rst_b = 1'h0;
      axi_done = 1'h0;
      tp_wr_en = 1'h0;
      tp_wr_addr = 3'h0;
      tp_wr_data = 16'h0;
      hready = 1'h1;
      hresp = 1'h0;
      hrdata = 32'h0;
      repeat (16) @(negedge core_clk);
      rst_b = 1'h1;
      i_host.send_byte(8'h20);
      i_host.send_byte(8'h01);
      repeat (40) @(posedge core_clk);
      chk(n_ahb + n_wst + n_rst, 0);
      chk(32'(hs_done), 0);
      chk(i_host.rxq.size(), 0);
      $display("test early bytes done");
      i_host.send_byte(HANDSHAKE_BYTE);
      wait_rx(1);
      chk(32'(i_host.rxq.pop_front()), 32'h61);
      repeat (SDIV + 4) @(posedge core_clk);
      chk(32'(hs_done), 1);
      $display("test handshake done");
      xfer(8'h01, 1'b0);
      $display("test write transfer done");
      for (int s = 1; s < 14; s++) cfg(s);
      $display("test config commands done");
      a0 = n_ahb + n_wst + n_rst;
      i_host.send_byte(8'h03);
      i_host.send_byte(8'h38);
      i_host.send_byte(8'h3c);
      repeat (40) @(posedge core_clk);
      chk(n_ahb + n_wst + n_rst - a0, 0);
      $display("test no-operation codes done");
      a0 = n_ahb;
      xfer(8'h16, 1'b1);
      chk(n_ahb - a0, 1);
      chk(a_addr, 32'h010);
      chk(a_data, 32'h0);
      $display("test exit and read done");
      a0 = n_ahb;
      xfer(8'h26, 1'b1);
      chk(n_ahb - a0, 1);
      chk(a_addr, 32'h084);
      chk(32'(a_wr), 0);
      $display("test register read with transfer done");
      final_report();
   end
endmodule
